// ===== verilog/rsq_pkg.sv
// Shared constants and types for the reference select and qualify block
package rsq_pkg;
  localparam int NUM_REF = 2;
  localparam int PRIO_W = 3;
  localparam logic [2:0] PRIO_NEVER = 3'h0;
  localparam int VTIMER_W = 16;
  localparam int PHASE_W = 16;
  localparam int STEP_TIMER_W = 16;
  localparam int TUNE_W = 16;
  // Register offsets (byte addresses, one word apart)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRIO = 8'h04;
  localparam logic [7:0] ADDR_MON_EN = 8'h08;
  localparam logic [7:0] ADDR_VTIMER0 = 8'h0c;
  localparam logic [7:0] ADDR_VTIMER1 = 8'h10;
  localparam logic [7:0] ADDR_SLEW = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PHASE = 8'h1c;
  // CTRL field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MANSEL_BIT = 2;
  localparam int CTRL_PINSEL_BIT = 3;
  localparam int CTRL_HITLESS_BIT = 4;
  localparam int CTRL_CANCEL_BIT = 5;
  localparam int CTRL_SLEW_EN_BIT = 6;
  localparam int CTRL_XO_BYP_BIT = 7;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] PRIO_RST = 6'h0a;
  localparam logic [7:0] MON_EN_RST = 8'h00;
  localparam logic [15:0] VTIMER_RST = 16'h0010;
  localparam logic [15:0] STEP_LIMIT_RST = 16'h0010;
  localparam logic [15:0] STEP_TIMER_RST = 16'h0008;

  typedef enum logic [1:0] {
    RSQ_AUTO_REV = 2'h0,
    RSQ_AUTO_NONREV = 2'h1,
    RSQ_MAN_FALLBACK = 2'h2,
    RSQ_MAN_HOLDOVER = 2'h3
  } rsq_mode_e;

  typedef enum logic [3:0] {
    ST_FREERUN = 4'h1,
    ST_HOLDOVER = 4'h2,
    ST_TRACK0 = 4'h4,
    ST_TRACK1 = 4'h8
  } rsq_state_e;

  // Per-input monitor flags and their enables
  typedef struct packed {
    logic freq;
    logic miss;
    logic runt;
    logic phase;
  } rsq_mon_s;
endpackage

// ===== verilog/rsq_qualify.sv
// Per-input monitor gating and validation timer
`timescale 1ns/1ps
`default_nettype none
module rsq_qualify #(
  parameter int TIMER_W = 16
) (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire rsq_pkg::rsq_mon_s mon_flags, // Raw monitor flags
  input wire rsq_pkg::rsq_mon_s mon_en, // Monitor enables
  input wire logic timer_en, // Validation timer enable
  input wire logic [TIMER_W-1:0] timer_len, // Validation time in cycles
  output rsq_pkg::rsq_mon_s flags_out, // Gated flags
  output logic valid // Input qualified
);
  logic [TIMER_W-1:0] cnt_reg, cnt_next;
  logic valid_reg, valid_next;
  logic any_flag;

  always_comb begin
    flags_out = mon_flags & mon_en;
    any_flag = |flags_out;
    cnt_next = cnt_reg;
    valid_next = valid_reg;
    if (any_flag) begin
      cnt_next = '0;
      valid_next = 1'b0;
    end else if (!timer_en) begin
      valid_next = 1'b1;
    end else if (cnt_reg >= timer_len) begin
      valid_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
    end
  end

  assign valid = valid_reg;
endmodule
`default_nettype wire

// ===== verilog/rsq_slew.sv
// Phase build-out and slew-limited removal of switchover offset
`timescale 1ns/1ps
`default_nettype none
module rsq_slew #(
  parameter int PW = 16,
  parameter int TW = 16
) (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic switch_evt, // Switchover or holdover exit pulse
  input wire logic [PW-1:0] phase_step, // Offset at switch, signed
  input wire logic hitless_en, // Hitless switching enable
  input wire logic cancel_en, // Phase cancellation enable
  input wire logic slew_en, // Slew control enable
  input wire logic force_slew, // Non-locked switch or holdover exit
  input wire logic [PW-1:0] step_limit, // Max step per interval
  input wire logic [TW-1:0] step_timer, // Interval in cycles
  output logic [PW-1:0] buildout, // Absorbed offset, signed
  output logic [PW-1:0] pass_phase // Offset passed to loop, signed
);
  logic [PW-1:0] bo_reg, bo_next, pass_reg, pass_next;
  logic [TW-1:0] tick_reg, tick_next;
  logic signed [PW-1:0] bo_s, lim_s;

  always_comb begin
    bo_next = bo_reg;
    pass_next = '0;
    tick_next = tick_reg;
    bo_s = bo_reg;
    lim_s = step_limit;
    if (switch_evt) begin
      if (hitless_en && (cancel_en || slew_en || force_slew)) begin
        bo_next = bo_reg + phase_step;
        tick_next = '0;
      end else begin
        pass_next = phase_step;
      end
    end else if ((slew_en || force_slew) && bo_reg != '0) begin
      if (tick_reg >= step_timer) begin
        tick_next = '0;
        if (bo_s > lim_s) begin
          bo_next = bo_reg - step_limit;
          pass_next = step_limit;
        end else if (bo_s < -lim_s) begin
          bo_next = bo_reg + step_limit;
          pass_next = -step_limit;
        end else begin
          bo_next = '0;
          pass_next = bo_reg;
        end
      end else begin
        tick_next = tick_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bo_reg <= '0;
      pass_reg <= '0;
      tick_reg <= '0;
    end else begin
      bo_reg <= bo_next;
      pass_reg <= pass_next;
      tick_reg <= tick_next;
    end
  end

  assign buildout = bo_reg;
  assign pass_phase = pass_reg;
endmodule
`default_nettype wire

// ===== verilog/rsq_top.sv
// Reference input selection and qualification for the DPLL
`timescale 1ns/1ps
`default_nettype none
module rsq_top #(
  parameter int NREF = rsq_pkg::NUM_REF
) (
  input wire logic CLK, // 25 MHz clock
  input wire logic RESET, // Sync reset, active high
  input wire logic [7:0] ADDR, // Register address
  input wire logic [31:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [31:0] RDATA, // Read data, cycle after RD
  input wire logic [NREF-1:0] REF_FREQ_ERR_HI, // Error above invalid threshold
  input wire logic [NREF-1:0] REF_FREQ_ERR_LO, // Error below valid threshold
  input wire logic [NREF-1:0] REF_MISS, // Missing pulse raw flag
  input wire logic [NREF-1:0] REF_RUNT, // Runt pulse raw flag
  input wire logic [NREF-1:0] REF_PHASE_BAD, // Phase-valid raw flag
  input wire logic [rsq_pkg::PHASE_W-1:0] REF_PHASE_DIFF, // Signed phase new minus old
  input wire logic FREQ_LOCKED, // Inputs frequency-locked
  input wire logic XO_IN_RANGE, // Crystal detector in range
  input wire logic HISTORY_VALID, // Tuning history valid
  input wire logic MAN_SEL_PIN, // Pin manual reference choice
  output logic [NREF*4-1:0] REF_FLAGS, // Gated flags of all inputs
  output logic [NREF-1:0] REF_VALID, // Qualified inputs
  output logic [NREF-1:0] SEL_ONEHOT, // Selected input
  output logic HOLDOVER, // In holdover
  output logic FREERUN, // In free-run
  output logic XO_VALID, // Crystal valid to PLL control
  output logic CRYSTAL_FREQ_LOSS_FLAG, // Crystal loss flag
  output logic [rsq_pkg::PHASE_W-1:0] PHASE_ADJ // Phase passed to the loop
);
  localparam int PW = rsq_pkg::PHASE_W;

  logic [7:0] ctrl_reg, ctrl_next;
  logic [NREF*3-1:0] prio_reg, prio_next;
  logic [NREF*4-1:0] mon_en_reg, mon_en_next;
  logic [NREF*rsq_pkg::VTIMER_W-1:0] vt_reg, vt_next;
  logic [NREF-1:0] vt_en_reg, vt_en_next;
  logic [PW-1:0] lim_reg, lim_next;
  logic [rsq_pkg::STEP_TIMER_W-1:0] stim_reg, stim_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [NREF-1:0] fdet_reg, fdet_next;
  logic xo_loss_reg, xo_loss_next;
  rsq_pkg::rsq_state_e st_reg, st_next;
  logic switch_evt_reg, switch_evt_next;
  logic force_reg, force_next;

  rsq_pkg::rsq_mode_e mode;
  logic man_idx;
  logic [NREF-1:0] valid;
  rsq_pkg::rsq_mon_s gated [NREF];
  logic best_found;
  logic best_idx;
  logic [2:0] best_prio;
  logic cur_idx;
  logic tracking;
  logic [PW-1:0] buildout;

  assign mode = rsq_pkg::rsq_mode_e'(ctrl_reg[rsq_pkg::CTRL_MODE_LSB +: 2]);
  assign man_idx = ctrl_reg[rsq_pkg::CTRL_PINSEL_BIT] ? MAN_SEL_PIN
                 : ctrl_reg[rsq_pkg::CTRL_MANSEL_BIT];
  assign tracking = (st_reg == rsq_pkg::ST_TRACK0) || (st_reg == rsq_pkg::ST_TRACK1);
  assign cur_idx = (st_reg == rsq_pkg::ST_TRACK1);

  // Per-input flag gating and validation timer
  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_ref
      rsq_pkg::rsq_mon_s raw;
      assign raw = '{freq: fdet_reg[g], miss: REF_MISS[g], runt: REF_RUNT[g],
                     phase: REF_PHASE_BAD[g]};
      rsq_qualify #(.TIMER_W(rsq_pkg::VTIMER_W)) u_qual (
        .clk(CLK),
        .reset(RESET),
        .mon_flags(raw),
        .mon_en(rsq_pkg::rsq_mon_s'(mon_en_reg[g*4 +: 4])),
        .timer_en(vt_en_reg[g]),
        .timer_len(vt_reg[g*rsq_pkg::VTIMER_W +: rsq_pkg::VTIMER_W]),
        .flags_out(gated[g]),
        .valid(valid[g])
      );
      assign REF_FLAGS[g*4 +: 4] = gated[g];
    end
  endgenerate

  // Best valid input; strict less-than keeps the lower index on ties
  always_comb begin
    best_found = 1'b0;
    best_idx = 1'b0;
    best_prio = 3'h7;
    for (int i = 0; i < NREF; i++) begin
      if (valid[i] && prio_reg[i*3 +: 3] != rsq_pkg::PRIO_NEVER) begin
        if (!best_found || prio_reg[i*3 +: 3] < best_prio) begin
          best_found = 1'b1;
          best_idx = 1'(i);
          best_prio = prio_reg[i*3 +: 3];
        end
      end
    end
  end

  // Reference state machine
  always_comb begin
    rsq_pkg::rsq_state_e lost;
    lost = HISTORY_VALID ? rsq_pkg::ST_HOLDOVER : rsq_pkg::ST_FREERUN;
    st_next = st_reg;
    unique case (mode)
      rsq_pkg::RSQ_AUTO_REV: begin
        if (best_found) begin
          st_next = best_idx ? rsq_pkg::ST_TRACK1 : rsq_pkg::ST_TRACK0;
        end else begin
          st_next = lost;
        end
      end
      rsq_pkg::RSQ_AUTO_NONREV: begin
        if (tracking && valid[cur_idx] && prio_reg[cur_idx*3 +: 3] != rsq_pkg::PRIO_NEVER) begin
          st_next = st_reg;
        end else if (best_found) begin
          st_next = best_idx ? rsq_pkg::ST_TRACK1 : rsq_pkg::ST_TRACK0;
        end else begin
          st_next = lost;
        end
      end
      rsq_pkg::RSQ_MAN_FALLBACK: begin
        if (valid[man_idx]) begin
          st_next = man_idx ? rsq_pkg::ST_TRACK1 : rsq_pkg::ST_TRACK0;
        end else if (best_found) begin
          st_next = best_idx ? rsq_pkg::ST_TRACK1 : rsq_pkg::ST_TRACK0;
        end else begin
          st_next = lost;
        end
      end
      rsq_pkg::RSQ_MAN_HOLDOVER: begin
        if (valid[man_idx]) begin
          st_next = man_idx ? rsq_pkg::ST_TRACK1 : rsq_pkg::ST_TRACK0;
        end else begin
          st_next = lost;
        end
      end
    endcase
    // Holdover only while history stays valid
    if (st_next == rsq_pkg::ST_HOLDOVER && !HISTORY_VALID) begin
      st_next = rsq_pkg::ST_FREERUN;
    end
    switch_evt_next = (st_next != st_reg) && (st_next == rsq_pkg::ST_TRACK0 || st_next == rsq_pkg::ST_TRACK1);
    // Forced slewing holds until the built-out offset is gone
    force_next = force_reg;
    if (switch_evt_next && (!tracking || !FREQ_LOCKED)) begin
      force_next = 1'b1;
    end else if (!switch_evt_reg && buildout == '0) begin
      force_next = 1'b0;
    end
  end

  // Flag hysteresis and crystal check
  always_comb begin
    for (int i = 0; i < NREF; i++) begin
      fdet_next[i] = fdet_reg[i];
      // Low report wins, so an input clears as soon as it is back in range
      if (REF_FREQ_ERR_LO[i]) begin
        fdet_next[i] = 1'b0;
      end else if (REF_FREQ_ERR_HI[i]) begin
        fdet_next[i] = 1'b1;
      end
    end
    xo_loss_next = !XO_IN_RANGE;
  end

  // Register writes and read data
  always_comb begin
    ctrl_next = ctrl_reg;
    prio_next = prio_reg;
    mon_en_next = mon_en_reg;
    vt_next = vt_reg;
    vt_en_next = vt_en_reg;
    lim_next = lim_reg;
    stim_next = stim_reg;
    rdata_next = '0;
    if (WR) begin
      unique case (ADDR)
        rsq_pkg::ADDR_CTRL: ctrl_next = WDATA[7:0];
        rsq_pkg::ADDR_PRIO: prio_next = WDATA[NREF*3-1:0];
        rsq_pkg::ADDR_MON_EN: begin
          mon_en_next = WDATA[NREF*4-1:0];
          vt_en_next = WDATA[16 +: NREF];
        end
        rsq_pkg::ADDR_VTIMER0: vt_next[0 +: rsq_pkg::VTIMER_W] = WDATA[15:0];
        rsq_pkg::ADDR_VTIMER1: vt_next[rsq_pkg::VTIMER_W +: rsq_pkg::VTIMER_W] = WDATA[15:0];
        rsq_pkg::ADDR_SLEW: begin
          lim_next = WDATA[15:0];
          stim_next = WDATA[31:16];
        end
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        rsq_pkg::ADDR_CTRL: rdata_next[7:0] = ctrl_reg;
        rsq_pkg::ADDR_PRIO: rdata_next[NREF*3-1:0] = prio_reg;
        rsq_pkg::ADDR_MON_EN: rdata_next = {14'h0, vt_en_reg, 8'h0, mon_en_reg};
        rsq_pkg::ADDR_VTIMER0: rdata_next[15:0] = vt_reg[0 +: rsq_pkg::VTIMER_W];
        rsq_pkg::ADDR_VTIMER1: rdata_next[15:0] = vt_reg[rsq_pkg::VTIMER_W +: rsq_pkg::VTIMER_W];
        rsq_pkg::ADDR_SLEW: rdata_next = {stim_reg, lim_reg};
        rsq_pkg::ADDR_STATUS: begin
          rdata_next[3:0] = tracking ? gated[cur_idx] : 4'h0;
          rdata_next[4] = xo_loss_reg;
          rdata_next[5 +: NREF] = valid;
          rdata_next[8 +: 4] = st_reg;
          rdata_next[12] = cur_idx;
        end
        rsq_pkg::ADDR_PHASE: rdata_next[PW-1:0] = buildout;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= rsq_pkg::CTRL_RST;
      prio_reg <= rsq_pkg::PRIO_RST;
      mon_en_reg <= rsq_pkg::MON_EN_RST;
      vt_reg <= {NREF{rsq_pkg::VTIMER_RST}};
      vt_en_reg <= '0;
      lim_reg <= rsq_pkg::STEP_LIMIT_RST;
      stim_reg <= rsq_pkg::STEP_TIMER_RST;
      rdata_reg <= '0;
      fdet_reg <= '0;
      xo_loss_reg <= 1'b1;
      st_reg <= rsq_pkg::ST_FREERUN;
      switch_evt_reg <= 1'b0;
      force_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prio_reg <= prio_next;
      mon_en_reg <= mon_en_next;
      vt_reg <= vt_next;
      vt_en_reg <= vt_en_next;
      lim_reg <= lim_next;
      stim_reg <= stim_next;
      rdata_reg <= rdata_next;
      fdet_reg <= fdet_next;
      xo_loss_reg <= xo_loss_next;
      st_reg <= st_next;
      switch_evt_reg <= switch_evt_next;
      force_reg <= force_next;
    end
  end

  // Build-out and slew act on the registered switch pulse
  rsq_slew #(.PW(PW), .TW(rsq_pkg::STEP_TIMER_W)) u_slew (
    .clk(CLK),
    .reset(RESET),
    .switch_evt(switch_evt_reg),
    .phase_step(REF_PHASE_DIFF),
    .hitless_en(ctrl_reg[rsq_pkg::CTRL_HITLESS_BIT]),
    .cancel_en(ctrl_reg[rsq_pkg::CTRL_CANCEL_BIT]),
    .slew_en(ctrl_reg[rsq_pkg::CTRL_SLEW_EN_BIT]),
    .force_slew(force_reg),
    .step_limit(lim_reg),
    .step_timer(stim_reg),
    .buildout(buildout),
    .pass_phase(PHASE_ADJ)
  );

  assign RDATA = rdata_reg;
  assign REF_VALID = valid;
  // Selection, holdover and free-run outputs decode the one-hot state register
  assign SEL_ONEHOT = {st_reg == rsq_pkg::ST_TRACK1, st_reg == rsq_pkg::ST_TRACK0};
  assign HOLDOVER = (st_reg == rsq_pkg::ST_HOLDOVER);
  assign FREERUN = (st_reg == rsq_pkg::ST_FREERUN);
  assign CRYSTAL_FREQ_LOSS_FLAG = xo_loss_reg;
  assign XO_VALID = ctrl_reg[rsq_pkg::CTRL_XO_BYP_BIT] | ~xo_loss_reg;
endmodule
`default_nettype wire

// ===== verif/rsq_ref_model.sv
// Far-side model of the two reference sources and their raw monitor flags
`timescale 1ns/1ps
`default_nettype none
module rsq_ref_model (
  input wire logic [1:0] bad, // Source faulty, per input
  input wire logic [1:0] mid, // Frequency error between both thresholds, per input
  output logic [1:0] freq_err_hi, // Error above invalid threshold
  output logic [1:0] freq_err_lo, // Error below valid threshold
  output logic [1:0] miss, // Missing pulse flag
  output logic [1:0] runt, // Runt pulse flag
  output logic [1:0] phase_bad // Phase-valid flag
);
  // Error jumps past both thresholds unless held between them
  assign freq_err_hi = bad & ~mid;
  assign freq_err_lo = ~bad & ~mid;
  // Ungapped clocks: window monitors flag only a faulty source
  assign miss = bad;
  assign runt = bad;
  // Not a 1PPS source, so the phase-valid monitor stays off and quiet
  assign phase_bad = 2'h0;
endmodule
`default_nettype wire

// ===== verif/rsq_top_properties.sv
// Concurrent checks on the reference select and qualify ports
`timescale 1ns/1ps
`default_nettype none
module rsq_top_properties #(
  parameter int NREF = 2
) (
  input wire logic CLK, // Clock
  input wire logic RESET, // Sync reset
  input wire logic [7:0] ADDR, // Address
  input wire logic [31:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic [NREF*4-1:0] REF_FLAGS, // Gated flags
  input wire logic [NREF-1:0] REF_VALID, // Qualified inputs
  input wire logic [NREF-1:0] SEL_ONEHOT, // Selected input
  input wire logic HOLDOVER, // Holdover
  input wire logic FREERUN, // Free-run
  input wire logic XO_VALID, // Crystal valid
  input wire logic CRYSTAL_FREQ_LOSS_FLAG, // Crystal loss
  input wire logic XO_IN_RANGE, // Crystal in range
  input wire logic HISTORY_VALID, // History valid
  input wire logic MAN_SEL_PIN, // Pin choice
  input wire logic FREQ_LOCKED, // Inputs locked
  input wire logic [rsq_pkg::PHASE_W-1:0] REF_PHASE_DIFF, // Phase new minus old
  input wire logic [rsq_pkg::PHASE_W-1:0] PHASE_ADJ // Passed phase
);
  logic [7:0] ctrl_reg, ctrl_next, mon_reg, mon_next;
  logic [5:0] prio_reg, prio_next;
  logic [15:0] lim_reg, lim_next;
  logic man_ch;
  // Shadow copies of the writable fields the checks depend on
  always_comb begin
    ctrl_next = ctrl_reg;
    mon_next = mon_reg;
    prio_next = prio_reg;
    lim_next = lim_reg;
    if (WR && ADDR == rsq_pkg::ADDR_CTRL) ctrl_next = WDATA[7:0];
    if (WR && ADDR == rsq_pkg::ADDR_MON_EN) mon_next = WDATA[7:0];
    if (WR && ADDR == rsq_pkg::ADDR_PRIO) prio_next = WDATA[5:0];
    if (WR && ADDR == rsq_pkg::ADDR_SLEW) lim_next = WDATA[15:0];
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= rsq_pkg::CTRL_RST;
      mon_reg <= rsq_pkg::MON_EN_RST;
      prio_reg <= rsq_pkg::PRIO_RST;
      lim_reg <= rsq_pkg::STEP_LIMIT_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      mon_reg <= mon_next;
      prio_reg <= prio_next;
      lim_reg <= lim_next;
    end
  end
  assign man_ch = ctrl_reg[3] ? MAN_SEL_PIN : ctrl_reg[2];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_switch;
    $past(SEL_ONEHOT) != 0 && SEL_ONEHOT != 0 && SEL_ONEHOT != $past(SEL_ONEHOT);
  endsequence
  sequence s_lost;
    SEL_ONEHOT != 0 && REF_VALID == 0;
  endsequence
  AST_XO_LOSS: assert property (1'b1 |=> CRYSTAL_FREQ_LOSS_FLAG == !$past(XO_IN_RANGE))
    else $error("crystal loss flag does not follow range");
  AST_XO_BYP: assert property (XO_VALID == (ctrl_reg[7] | !CRYSTAL_FREQ_LOSS_FLAG))
    else $error("crystal valid wrong for bypass and loss");
  AST_ONE_STATE: assert property ($onehot({SEL_ONEHOT, HOLDOVER, FREERUN}))
    else $error("state outputs not one-hot");
  AST_MASK: assert property ((REF_FLAGS & ~mon_reg & ~$past(mon_reg)) == 0)
    else $error("flag of disabled monitor raised");
  AST_DROP: assert property (REF_FLAGS[3:0] != 0 |-> ##[0:1] !REF_VALID[0])
    else $error("input zero stays valid with a flag");
  AST_RISE: assert property ($rose(REF_VALID[1]) |-> $past(REF_FLAGS[7:4]) == 0)
    else $error("input one qualified while flagged");
  AST_BEST: assert property (ctrl_reg[1:0] == 2'h0 && REF_VALID == 2'b11 && XO_VALID && prio_reg[2:0] != 0 &&
    (prio_reg[5:3] == 0 || prio_reg[2:0] <= prio_reg[5:3]) |=> SEL_ONEHOT == 2'b01)
    else $error("revertive mode missed best input");
  AST_NONREV: assert property (ctrl_reg[1:0] == 2'h1 && SEL_ONEHOT == 2'b10 && REF_VALID[1] &&
    prio_reg[5:3] != 0 |=> SEL_ONEHOT == 2'b10)
    else $error("non-revertive mode left a valid input");
  AST_NOREF: assert property (s_lost ##0 HISTORY_VALID |=> HOLDOVER)
    else $error("no holdover after loss of all inputs");
  AST_MAN_HOLD: assert property (ctrl_reg[1:0] == 2'h3 && !man_ch && SEL_ONEHOT == 2'b01 &&
    REF_VALID == 2'b10 |=> SEL_ONEHOT == 2'b00)
    else $error("manual holdover mode tried another input");
  AST_HITLESS_OFF: assert property (s_switch ##0 !ctrl_reg[4] |-> ##[1:3] PHASE_ADJ == REF_PHASE_DIFF)
    else $error("full offset not passed on switch");
  AST_BUILDOUT: assert property (s_switch ##0 (ctrl_reg[5:4] == 2'h3 && !ctrl_reg[6] && FREQ_LOCKED)
    |-> (PHASE_ADJ == 16'h0)[*4])
    else $error("offset leaked with cancellation");
  AST_SLEW: assert property (ctrl_reg[4] && ctrl_reg[6] |->
    (PHASE_ADJ[15] ? 16'h0 - PHASE_ADJ : PHASE_ADJ) <= lim_reg)
    else $error("phase step above slew limit");
endmodule
bind rsq_top rsq_top_properties #(.NREF(NREF)) rsq_top_properties_i (
  .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .REF_FLAGS(REF_FLAGS),
  .REF_VALID(REF_VALID), .SEL_ONEHOT(SEL_ONEHOT), .HOLDOVER(HOLDOVER), .FREERUN(FREERUN),
  .XO_VALID(XO_VALID), .CRYSTAL_FREQ_LOSS_FLAG(CRYSTAL_FREQ_LOSS_FLAG), .XO_IN_RANGE(XO_IN_RANGE),
  .HISTORY_VALID(HISTORY_VALID), .MAN_SEL_PIN(MAN_SEL_PIN), .FREQ_LOCKED(FREQ_LOCKED),
  .REF_PHASE_DIFF(REF_PHASE_DIFF), .PHASE_ADJ(PHASE_ADJ));
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for reference selection, qualification and switching
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, reset, wr, rd, hist, locked, xo_in, pin, holdover, freerun, xo_valid, xo_loss;
  logic [7:0] addr, ref_flags;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bad, mid, ref_valid, sel, err_hi, err_lo, miss, runt, ph_bad;
  logic [15:0] diff, phase_adj, sum;
  int err_total, n_tests;
  rsq_ref_model rsq_ref_model_i (.bad(bad), .freq_err_hi(err_hi), .freq_err_lo(err_lo), .miss(miss),
    .runt(runt), .phase_bad(ph_bad), .mid(mid));
  rsq_top rsq_top_i (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .REF_FREQ_ERR_HI(err_hi), .REF_FREQ_ERR_LO(err_lo), .REF_MISS(miss), .REF_RUNT(runt),
    .REF_PHASE_BAD(ph_bad), .REF_PHASE_DIFF(diff), .FREQ_LOCKED(locked), .XO_IN_RANGE(xo_in),
    .HISTORY_VALID(hist), .MAN_SEL_PIN(pin), .REF_FLAGS(ref_flags), .REF_VALID(ref_valid),
    .SEL_ONEHOT(sel), .HOLDOVER(holdover), .FREERUN(freerun), .XO_VALID(xo_valid),
    .CRYSTAL_FREQ_LOSS_FLAG(xo_loss), .PHASE_ADJ(phase_adj));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Waits for {valid, selected, holdover, free-run}, then compares it
  task automatic wait_st(input logic [5:0] e);
    for (int k = 0; k < 80 && {ref_valid, sel, holdover, freerun} !== e; k++) cyc(1);
    chk({ref_valid, sel, holdover, freerun}, e);
  endtask
  // Faults input i to force a switch, sums the passed phase, then heals it
  task automatic sw(input int i, input int n);
    @(posedge clk) bad[i] <= 1'b1;
    sum = 16'h0;
    repeat (n) begin
      cyc(1);
      sum = sum + phase_adj;
    end
    @(posedge clk) bad[i] <= 1'b0;
    cyc(40);
  endtask
  task automatic t_reset;
    logic [7:0] a [7] = '{rsq_pkg::ADDR_CTRL, rsq_pkg::ADDR_PRIO, rsq_pkg::ADDR_MON_EN, rsq_pkg::ADDR_VTIMER0,
      rsq_pkg::ADDR_VTIMER1, rsq_pkg::ADDR_SLEW, 8'h20};
    logic [31:0] e [7] = '{32'h0, 32'h0a, 32'h0, 32'h10, 32'h10, 32'h0008_0010, 32'h0};
    for (int k = 0; k < 7; k++) begin
      rd_reg(a[k], rv);
      chk(rv, e[k]);
    end
    rd_reg(rsq_pkg::ADDR_STATUS, rv);
    chk(rv, 32'h0000_1870);
    chk({xo_loss, xo_valid}, 2'b10);
    @(posedge clk) xo_in <= 1'b1;
    cyc(3);
    chk({xo_loss, xo_valid}, 2'b01);
    @(posedge clk) xo_in <= 1'b0;
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h80);
    cyc(3);
    chk({xo_loss, xo_valid}, 2'b11);
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h00);
    xo_in <= 1'b1;
  endtask
  task automatic t_qualify;
    int k;
    wr_reg(rsq_pkg::ADDR_MON_EN, 32'h0003_00ee);
    wr_reg(rsq_pkg::ADDR_VTIMER0, 32'h5);
    wait_st(6'b00_00_01);
    chk(ref_flags, 8'hee);
    @(posedge clk) bad <= 2'b10;
    for (k = 0; k < 40 && ref_valid[0] !== 1'b1; k++) cyc(1);
    chk(k >= 6 && k <= 9, 1'b1);
    wait_st(6'b01_01_00);
    wr_reg(rsq_pkg::ADDR_MON_EN, 32'h0003_000e);
    cyc(2);
    chk(ref_flags[7:4], 4'h0);
    wait_st(6'b11_10_00);
    @(posedge clk) bad <= 2'b11;
    cyc(4);
    chk(ref_flags, 8'h0e);
    rd_reg(rsq_pkg::ADDR_STATUS, rv);
    chk({rv[12:8], rv[3:0]}, 9'h180);
    wr_reg(rsq_pkg::ADDR_MON_EN, 32'h0003_00ee);
    bad <= 2'b00;
    wait_st(6'b11_10_00);
    @(posedge clk) mid <= 2'b01;
    bad <= 2'b01;
    cyc(3);
    chk(ref_flags[3:0], 4'h6);
    @(posedge clk) mid <= 2'b00;
    cyc(2);
    chk(ref_flags[3:0], 4'he);
    @(posedge clk) mid <= 2'b01;
    bad <= 2'b00;
    cyc(2);
    chk(ref_flags[3:0], 4'h8);
    @(posedge clk) mid <= 2'b00;
    wait_st(6'b11_10_00);
  endtask
  task automatic t_select;
    wr_reg(rsq_pkg::ADDR_PRIO, 32'h1b);
    wait_st(6'b11_01_00);
    wr_reg(rsq_pkg::ADDR_PRIO, 32'h18);
    wait_st(6'b11_10_00);
    wr_reg(rsq_pkg::ADDR_PRIO, 32'h11);
    wait_st(6'b11_01_00);
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h01);
    wr_reg(rsq_pkg::ADDR_PRIO, 32'h0a);
    cyc(5);
    chk({ref_valid, sel}, 4'b1101);
    @(posedge clk) bad <= 2'b01;
    wait_st(6'b10_10_00);
    wr_reg(rsq_pkg::ADDR_PRIO, 32'h11);
    bad <= 2'b00;
    wait_st(6'b11_10_00);
    cyc(5);
    chk({ref_valid, sel}, 4'b1110);
    @(posedge clk) hist <= 1'b1;
    bad <= 2'b11;
    wait_st(6'b00_00_10);
    @(posedge clk) hist <= 1'b0;
    wait_st(6'b00_00_01);
    @(posedge clk) hist <= 1'b1;
    bad <= 2'b10;
    wait_st(6'b01_01_00);
    @(posedge clk) bad <= 2'b00;
    wait_st(6'b11_01_00);
  endtask
  task automatic t_manual;
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h07);
    wait_st(6'b11_10_00);
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h0b);
    wait_st(6'b11_01_00);
    @(posedge clk) bad <= 2'b01;
    wait_st(6'b10_00_10);
    @(posedge clk) bad <= 2'b00;
    wait_st(6'b11_01_00);
    @(posedge clk) pin <= 1'b1;
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h0a);
    wait_st(6'b11_10_00);
    @(posedge clk) bad <= 2'b10;
    wait_st(6'b01_01_00);
    @(posedge clk) bad <= 2'b11;
    wait_st(6'b00_00_10);
    @(posedge clk) bad <= 2'b00;
    wait_st(6'b11_10_00);
  endtask
  task automatic t_phase;
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h01);
    sw(1, 12);
    chk(sum, 16'h0040);
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h31);
    sw(0, 12);
    chk(sum, 16'h0000);
    rd_reg(rsq_pkg::ADDR_PHASE, rv);
    chk(rv[15:0], 16'h0040);
    wr_reg(rsq_pkg::ADDR_SLEW, 32'h0003_0010);
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h71);
    sw(1, 200);
    chk(sum, 16'h0080);
    rd_reg(rsq_pkg::ADDR_PHASE, rv);
    chk(rv[15:0], 16'h0000);
    @(posedge clk) locked <= 1'b0;
    wr_reg(rsq_pkg::ADDR_CTRL, 32'h11);
    sw(0, 6);
    chk(sum, 16'h0000);
    rd_reg(rsq_pkg::ADDR_PHASE, rv);
    chk(rv[15:0], 16'h0000);
  endtask
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    bad = 2'b11;
    mid = 2'b00;
    hist = 1'b0;
    locked = 1'b1;
    xo_in = 1'b0;
    pin = 1'b0;
    diff = 16'h0040;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_qualify;
    t_select;
    t_manual;
    t_phase;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
